// *** capture_interval_timer.sv ***
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module capture_interval_timer
    import timer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic watch_clk_i,
    input wire logic capture_pin_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o
);
    // whole block state, registered in one process
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [1:0] wsync;
        logic wprev;
        logic [1:0] wdiv;
        logic sel_prev;
        logic [7:0] count;
        logic [7:0] mode;
        logic [7:0] fall_cap;
        logic [7:0] rise_cap;
        logic [7:0] clk_stop;
        logic pin_sel;
        logic filt_en;
        logic irq_req;
        logic irq_en;
        logic arm_high;
        logic arm_low;
        logic cap_prev;
        logic [7:0] rdata;
        logic irq;
    } state_t;

    state_t q;
    state_t d;

    logic rst_meta_q;
    logic rst_n;
    logic run;
    logic sel_clk;
    logic sel_rise;
    logic sel_fall;
    logic sample;
    logic filt_out;
    logic filt_ready;
    logic cap_sig;
    logic rise_edge;
    logic fall_edge;
    logic clr_hit;
    logic ovf;
    logic ovf_high;
    logic ovf_low;
    logic edge_irq;
    logic wr_mode;
    logic wr_stop;
    logic wr_port;
    logic wr_irq;
    logic rd_mode;
    logic clr_high;
    logic clr_low;
    logic [7:0] rd_val;

    // sticky flag update, a set in the same cycle beats the clear
    function automatic logic flag_next(
        input logic cur,
        input logic set,
        input logic clr
    );
        flag_next = set | (cur & ~clr);
    endfunction : flag_next

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // count clock selection and its edges
    always_comb begin
        run = q.clk_stop[STBY_BIT]; // standby when low
        case (clk_sel_t'(q.mode[CKS_HI_BIT:CKS_LO_BIT]))
            CKS_DIV64: begin
                sel_clk = q.div[DIV64_TAP];
            end
            CKS_DIV32: begin
                sel_clk = q.div[DIV32_TAP];
            end
            CKS_DIV2: begin
                sel_clk = q.div[DIV2_TAP];
            end
            default: begin
                sel_clk = q.wdiv[WDIV_TAP]; // synced watch/4
            end
        endcase
        // a select change that drops the level counts as a falling edge
        sel_rise = run & sel_clk & ~q.sel_prev;
        sel_fall = run & ~sel_clk & q.sel_prev;
        // filter off: every system clock; on: rising edge of count clock
        sample = run & (q.filt_en ? sel_rise : 1'b1);
    end

    capture_noise_filter u_filter (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .sample_i(sample),
        .bypass_i(~q.filt_en),
        .din_i(capture_pin_i),
        .dout_o(filt_out),
        .ready_o(filt_ready)
    );

    // capture signal edges and counter events
    always_comb begin
        // pin not selected reads as low, so a select change can make
        // an edge; it is handled like any pin edge
        cap_sig = q.pin_sel & filt_out;
        // filter output switching after an enable change is an edge
        rise_edge = run & filt_ready & cap_sig & ~q.cap_prev;
        fall_edge = run & filt_ready & ~cap_sig & q.cap_prev;
        // clearing only in capture mode
        clr_hit = q.pin_sel & ((rise_edge & q.mode[CLR_RISE_BIT]) |
                               (fall_edge & q.mode[CLR_FALL_BIT]));
        // increments on the falling edge of the count clock
        ovf = sel_fall & ~clr_hit & (q.count == COUNT_MAX);
        ovf_high = ovf & q.pin_sel & cap_sig;
        ovf_low = ovf & ~(q.pin_sel & cap_sig);
        // interrupt edge choice
        edge_irq = q.mode[IEDGE_BIT] ? fall_edge : rise_edge;
    end

    // register port decode
    always_comb begin
        wr_mode = 1'b0;
        wr_stop = 1'b0;
        wr_port = 1'b0;
        wr_irq = 1'b0;
        rd_mode = 1'b0;
        if (addr_i == MODE_ADDR) begin
            wr_mode = wr_i & run; // mode register held in standby
            rd_mode = rd_i;
        end else if (addr_i == CLK_STOP_ADDR) begin
            wr_stop = wr_i;
        end else if (addr_i == PORT_CTRL_ADDR) begin
            wr_port = wr_i;
        end else if (addr_i == IRQ_CTRL_ADDR) begin
            wr_irq = wr_i;
        end
        // a zero write clears only a flag already seen as one
        clr_high = wr_mode & ~wdata_i[OVERFLOW_HIGH_FLAG_BIT] & q.arm_high;
        clr_low = wr_mode & ~wdata_i[OVERFLOW_LOW_FLAG_BIT] & q.arm_low;
    end

    // read mux; the counter has no address
    always_comb begin
        rd_val = READ_IDLE;
        if (addr_i == MODE_ADDR) begin
            rd_val = q.mode;
        end else if (addr_i == FALL_CAP_ADDR) begin
            rd_val = q.fall_cap;
        end else if (addr_i == RISE_CAP_ADDR) begin
            rd_val = q.rise_cap;
        end else if (addr_i == CLK_STOP_ADDR) begin
            rd_val = q.clk_stop;
        end else if (addr_i == PORT_CTRL_ADDR) begin
            rd_val[PIN_SEL_BIT] = q.pin_sel;
            rd_val[FILT_EN_BIT] = q.filt_en;
        end else if (addr_i == IRQ_CTRL_ADDR) begin
            rd_val[IRQ_REQ_BIT] = q.irq_req;
            rd_val[IRQ_EN_BIT] = q.irq_en;
        end
    end

    // next state of the whole block
    always_comb begin
        d = q;
        // prescaler stops in standby
        if (run) begin
            d.div = q.div + 6'h01;
        end
        // watch clock: two flops, only the second is looked at
        d.wsync = {q.wsync[0], watch_clk_i};
        d.wprev = q.wsync[1];
        if (run && q.wsync[1] && !q.wprev) begin
            d.wdiv = q.wdiv + 2'h1;
        end
        d.sel_prev = sel_clk;
        d.cap_prev = cap_sig;

        // counter: clear wins over increment
        if (clr_hit) begin
            d.count = COUNT_RST;
        end else if (sel_fall) begin
            d.count = q.count + 8'h01; // wraps FF to 00
        end

        // edge captures take the count before any clear
        if (rise_edge) begin
            d.rise_cap = q.count;
        end
        if (fall_edge) begin
            d.fall_cap = q.count;
        end

        // software fields of the mode register
        if (wr_mode) begin
            d.mode[OVERFLOW_IRQ_ENABLE_BIT:CKS_LO_BIT] = wdata_i[OVERFLOW_IRQ_ENABLE_BIT:CKS_LO_BIT];
        end
        // overflow flags: hardware set only, software write of 1 ignored
        d.mode[OVERFLOW_HIGH_FLAG_BIT] = flag_next(q.mode[OVERFLOW_HIGH_FLAG_BIT], ovf_high, clr_high);
        d.mode[OVERFLOW_LOW_FLAG_BIT] = flag_next(q.mode[OVERFLOW_LOW_FLAG_BIT], ovf_low, clr_low);

        // a read of a set flag arms its clear; the clear disarms it
        if (clr_high) begin
            d.arm_high = 1'b0;
        end else if (rd_mode && q.mode[OVERFLOW_HIGH_FLAG_BIT]) begin
            d.arm_high = 1'b1;
        end
        if (clr_low) begin
            d.arm_low = 1'b0;
        end else if (rd_mode && q.mode[OVERFLOW_LOW_FLAG_BIT]) begin
            d.arm_low = 1'b1;
        end

        // standby control stays writable so the block can be woken
        if (wr_stop) begin
            d.clk_stop = wdata_i;
        end
        if (wr_port) begin
            d.pin_sel = wdata_i[PIN_SEL_BIT];
            d.filt_en = wdata_i[FILT_EN_BIT];
        end
        if (wr_irq) begin
            d.irq_en = wdata_i[IRQ_EN_BIT];
        end

        // request flag from edges or enabled overflows
        d.irq_req = flag_next(q.irq_req,
                              edge_irq | ((ovf_high | ovf_low) & q.mode[OVERFLOW_IRQ_ENABLE_BIT]),
                              wr_irq & ~wdata_i[IRQ_REQ_BIT]);
        // follows the registered flag and enable, so a read of both agrees with the pin
        d.irq = q.irq_req & q.irq_en;

        // read data stand only in the cycle after the strobe
        d.rdata = rd_i ? rd_val : READ_IDLE;
    end

    // single state register; reset to documented values
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q.div <= '0;
            q.wsync <= '0;
            q.wprev <= 1'b0;
            q.wdiv <= '0;
            q.sel_prev <= 1'b0;
            q.count <= COUNT_RST;
            q.mode <= MODE_RST; // sys/64 selected
            q.fall_cap <= CAP_RST;
            q.rise_cap <= CAP_RST;
            q.clk_stop <= CLK_STOP_RST;
            q.pin_sel <= 1'b0;
            q.filt_en <= 1'b0;
            q.irq_req <= 1'b0;
            q.irq_en <= 1'b0;
            q.arm_high <= 1'b0;
            q.arm_low <= 1'b0;
            q.cap_prev <= 1'b0;
            q.rdata <= READ_IDLE;
            q.irq <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign rdata_o = q.rdata;
    assign irq_o = q.irq;
endmodule : capture_interval_timer
`default_nettype wire

// *** capture_noise_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
module capture_noise_filter
    import timer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sample_i,
    input wire logic bypass_i,
    input wire logic din_i,
    output logic dout_o,
    output logic ready_o
);
    typedef struct packed {
        logic [FILTER_STAGES-1:0] stages;
        logic out;
        logic ready;
    } filt_state_t;

    filt_state_t q;
    filt_state_t d;

    // shift on each sample, match detector decides the output
    always_comb begin
        d = q;
        if (sample_i) begin
            d.stages = {q.stages[FILTER_STAGES-2:0], din_i};
            if (d.stages == FILTER_LOW) begin
                d.ready = 1'b1;
            end
            if (bypass_i) begin
                d.out = din_i; // per-clock sampling, no match wait
            end else if (d.stages == FILTER_HIGH) begin
                d.out = 1'b1;
            end else if (d.stages == FILTER_LOW) begin
                d.out = 1'b0;
            end
        end
    end

    // latches start high so five low samples are needed
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q.stages <= FILTER_RST;
            q.out <= 1'b0;
            q.ready <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign dout_o = q.out;
    assign ready_o = q.ready;
endmodule : capture_noise_filter
`default_nettype wire

// *** capture_source.sv ***
`timescale 1ns/10ps
`default_nettype none
module capture_source (
    input wire logic clk_i,
    output logic pin_o
);
    initial pin_o = 1'b0;

    // widths are whole system clocks; only a commanded glitch goes under the filter minimum
    task automatic pulse(input int hi, input int lo);
        @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (hi) @(posedge clk_i);
        pin_o <= 1'b0;
        repeat (lo) @(posedge clk_i);
    endtask : pulse

    task automatic level(input logic v);
        @(posedge clk_i);
        pin_o <= v;
    endtask : level
endmodule : capture_source
`default_nettype wire

// *** test_capture_interval_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_capture_interval_timer;
    import timer_pkg::*;
    localparam int LIMIT = 20000;
    localparam int W = 192;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic watch_clk_i = 1'b0;
    logic pin;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o;
    logic [7:0] a;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    // count periods in system clocks; watch clock half period is 15 ns
    int per [4] = '{64, 32, 2, 12};

    capture_interval_timer u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .watch_clk_i(watch_clk_i),
        .capture_pin_i(pin), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .irq_o(irq_o));
    capture_source src (.clk_i(clk_i), .pin_o(pin));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // unrelated phase to the system clock
    initial begin
        #3;
        forever #15 watch_clk_i = ~watch_clk_i;
    end
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= ad;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] ad, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    // modular distance so counts near a wrap still compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] tol);
        logic [7:0] dp;
        logic [7:0] dn;
        dp = got - exp;
        dn = exp - got;
        total_checks++;
        if (!((dp <= tol) === 1'b1 || (dn <= tol) === 1'b1)) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdc(input logic [15:0] ad, input logic [7:0] exp, input logic [7:0] tol);
        logic [7:0] d;
        rd(ad, d);
        chk(d, exp, tol);
    endtask : rdc

    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rdc(MODE_ADDR, MODE_RST, 8'h00);
        rdc(FALL_CAP_ADDR, CAP_RST, 8'h00);
        rdc(CLK_STOP_ADDR, CLK_STOP_RST, 8'h00);
        wr(RISE_CAP_ADDR, 8'h5A);
        rdc(RISE_CAP_ADDR, CAP_RST, 8'h00);
        rdc(16'h0000, READ_IDLE, 8'h00);
        $display("test reset_values done");
        // one pulse per clock source; the capture gap measures the count rate
        wr(PORT_CTRL_ADDR, 8'h01);
        rdc(PORT_CTRL_ADDR, 8'h01, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(MODE_ADDR, {6'h00, c[1:0]});
            repeat (8) @(posedge clk_i);
            src.pulse(W, 8);
            rd(RISE_CAP_ADDR, a);
            rdc(FALL_CAP_ADDR, a + 8'(W / per[c]), 8'h01);
        end
        rdc(IRQ_CTRL_ADDR, 8'h01, 8'h00);
        $display("test clock_select done");
        // falling edge requests, both edges clear the count
        wr(IRQ_CTRL_ADDR, 8'h02);
        wr(MODE_ADDR, 8'h1E);
        src.pulse(100, 8);
        rdc(FALL_CAP_ADDR, 8'h32, 8'h01);
        rdc(IRQ_CTRL_ADDR, 8'h03, 8'h00);
        wr(IRQ_CTRL_ADDR, 8'h02);
        repeat (3) @(posedge clk_i);
        chk({7'h00, irq_o}, 8'h00, 8'h00);
        // leaving capture mode with the pin high is a falling edge
        src.level(1'b1);
        repeat (8) @(posedge clk_i);
        wr(PORT_CTRL_ADDR, 8'h00);
        repeat (4) @(posedge clk_i);
        rdc(IRQ_CTRL_ADDR, 8'h03, 8'h00);
        wr(IRQ_CTRL_ADDR, 8'h02);
        rdc(IRQ_CTRL_ADDR, 8'h02, 8'h00);
        src.level(1'b0);
        $display("test edges done");
        // standby blocks mode writes
        wr(CLK_STOP_ADDR, 8'hF7);
        rdc(CLK_STOP_ADDR, 8'hF7, 8'h00);
        wr(MODE_ADDR, 8'h01);
        rd(MODE_ADDR, a);
        chk(a & 8'h3F, 8'h1E, 8'h00);
        wr(CLK_STOP_ADDR, CLK_STOP_RST);
        $display("test standby done");
        // interval overflow, flag clearing, writes of one refused
        rd(MODE_ADDR, a);
        wr(MODE_ADDR, 8'h22);
        wr(IRQ_CTRL_ADDR, 8'h00);
        repeat (520) @(posedge clk_i);
        rdc(MODE_ADDR, 8'h62, 8'h00);
        rdc(IRQ_CTRL_ADDR, 8'h01, 8'h00);
        wr(MODE_ADDR, 8'h22);
        rdc(MODE_ADDR, 8'h22, 8'h00);
        wr(MODE_ADDR, 8'hE2);
        rdc(MODE_ADDR, 8'h22, 8'h00);
        // capture mode overflow with the pin high
        src.level(1'b1);
        wr(PORT_CTRL_ADDR, 8'h01);
        repeat (520) @(posedge clk_i);
        rdc(MODE_ADDR, 8'hA2, 8'h00);
        wr(IRQ_CTRL_ADDR, 8'h03);
        repeat (3) @(posedge clk_i);
        chk({7'h00, irq_o}, 8'h01, 8'h00);
        $display("test overflow done");
        // filter on: a glitch is dropped, a long pulse is measured
        wr(PORT_CTRL_ADDR, 8'h00);
        src.level(1'b0);
        wr(PORT_CTRL_ADDR, 8'h03);
        wr(MODE_ADDR, 8'h02);
        repeat (20) @(posedge clk_i);
        wr(IRQ_CTRL_ADDR, 8'h02);
        src.pulse(6, 20);
        rdc(IRQ_CTRL_ADDR, 8'h02, 8'h00);
        src.pulse(40, 20);
        rd(RISE_CAP_ADDR, a);
        rdc(FALL_CAP_ADDR, a + 8'h14, 8'h01);
        rdc(IRQ_CTRL_ADDR, 8'h03, 8'h00);
        $display("test filter done");
        stop_test();
    end
endmodule : test_capture_interval_timer
`default_nettype wire

// *** timer_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module timer_monitor
    import timer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic watch_clk_i,
    input wire logic capture_pin_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic irq_o
);
    logic stby_q;
    logic [7:0] wlast_q;
    logic mapped;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // shadow of standby bit and last written byte; mode writes drop while standby is low
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stby_q <= 1'b1;
            wlast_q <= 8'h00;
        end else if (wr_i) begin
            wlast_q <= wdata_i;
            if (addr_i == CLK_STOP_ADDR) begin
                stby_q <= wdata_i[STBY_BIT];
            end
        end
    end

    // every place that answers a read; the counter has none
    assign mapped = addr_i inside {MODE_ADDR, FALL_CAP_ADDR, RISE_CAP_ADDR, CLK_STOP_ADDR,
                                   PORT_CTRL_ADDR, IRQ_CTRL_ADDR};

    // write, one idle cycle, then read of the same place
    sequence wr_then_rd(logic [15:0] a);
        wr_i && addr_i == a ##2 rd_i && addr_i == a;
    endsequence

    idle_read_a: assert property (!rd_i |=> rdata_o == READ_IDLE)
        else $error("read data not idle outside a read");
    unmapped_read_a: assert property (rd_i && !mapped |=> rdata_o == READ_IDLE)
        else $error("unmapped read returned data");
    stop_reg_a: assert property (wr_then_rd(CLK_STOP_ADDR) |=> rdata_o == wlast_q)
        else $error("clock stop register lost written value");
    port_reg_a: assert property (wr_then_rd(PORT_CTRL_ADDR) |=> rdata_o[1:0] == wlast_q[1:0])
        else $error("port control bits lost written value");
    mode_reg_a: assert property (stby_q ##0 wr_then_rd(MODE_ADDR) |=> rdata_o[5:0] == wlast_q[5:0])
        else $error("mode control bits lost written value");
    irq_enable_a: assert property (wr_then_rd(IRQ_CTRL_ADDR) |=> rdata_o[IRQ_EN_BIT] == wlast_q[IRQ_EN_BIT])
        else $error("interrupt enable lost written value");
    irq_level_a: assert property (rd_i && addr_i == IRQ_CTRL_ADDR |=> irq_o == (rdata_o[IRQ_REQ_BIT] && rdata_o[IRQ_EN_BIT]))
        else $error("interrupt output disagrees with flag and enable");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
        else $error("interrupt dropped without a write");
endmodule : timer_monitor

bind capture_interval_timer timer_monitor u_mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .watch_clk_i(watch_clk_i), .capture_pin_i(capture_pin_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// *** timer_pkg.sv ***
// Summary of operation
// - clock select 00 sys/64, 01 sys/32, 10 sys/2, 11 watch/4; reset 00
// - standby bit in clock stop register: 0 halts timer, 1 runs; resets 1
// - filter shifts input through five latches, updates only when all agree
// - filter samples on system clock when off, selected clock rise when on
// - after reset filter output valid only after five low samples
// - with filter on, capture acts five sampling cycles after pin edge
// - pin select 1 gives capture timer, 0 gives interval timer
// - reset zeroes mode, counter, both captures; counting starts on sys/64
// - rising edge copies count to rise capture, falling edge to fall capture
// - edge chosen by edge select sets request flag; irq out if enabled
// - in capture mode counter clears on edges chosen by clear select
// - capture mode overflow sets high flag if input high, else low flag
// - overflow flag set with overflow enable sets request flag
// - interval mode counts selected clock, wrap FF to 00 sets low flag
// - filter enable change may make an edge, processed as a real one
// - pin select change may make an edge, processed as a real one
// - clear select 00 none, 01 falling, 10 rising, 11 both edges
// - overflow flags clear only by writing 0 after reading 1
// - edge select 0 rising, 1 falling as interrupt source
// - counter is neither readable nor writable by software
package timer_pkg;
    // register addresses on the 16-bit register port
    localparam logic [15:0] MODE_ADDR = 16'hFFBC;
    localparam logic [15:0] FALL_CAP_ADDR = 16'hFFBD;
    localparam logic [15:0] RISE_CAP_ADDR = 16'hFFBE;
    localparam logic [15:0] CLK_STOP_ADDR = 16'hFFFA;
    localparam logic [15:0] PORT_CTRL_ADDR = 16'hFFC0;
    localparam logic [15:0] IRQ_CTRL_ADDR = 16'hFFC1;
    // mode register fields
    localparam int OVERFLOW_HIGH_FLAG_BIT = 7;
    localparam int OVERFLOW_LOW_FLAG_BIT = 6;
    localparam int OVERFLOW_IRQ_ENABLE_BIT = 5;
    localparam int IEDGE_BIT = 4;
    localparam int CLR_RISE_BIT = 3;
    localparam int CLR_FALL_BIT = 2;
    localparam int CKS_HI_BIT = 1;
    localparam int CKS_LO_BIT = 0;
    // other register fields
    localparam int STBY_BIT = 3;
    localparam int PIN_SEL_BIT = 0;
    localparam int FILT_EN_BIT = 1;
    localparam int IRQ_REQ_BIT = 0;
    localparam int IRQ_EN_BIT = 1;
    // reset values and counter maximum
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CAP_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CLK_STOP_RST = 8'hFF;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] READ_IDLE = 8'h00;
    // prescaler taps
    localparam int DIV_W = 6;
    localparam int DIV64_TAP = 5;
    localparam int DIV32_TAP = 4;
    localparam int DIV2_TAP = 0;
    localparam int WDIV_TAP = 1;
    // noise filter
    localparam int FILTER_STAGES = 5;
    localparam logic [4:0] FILTER_RST = 5'h1F;
    localparam logic [4:0] FILTER_LOW = 5'h00;
    localparam logic [4:0] FILTER_HIGH = 5'h1F;

    typedef enum logic [1:0] {
        CKS_DIV64 = 2'b00,
        CKS_DIV32 = 2'b01,
        CKS_DIV2 = 2'b10,
        CKS_WATCH4 = 2'b11
    } clk_sel_t;
endpackage : timer_pkg
